// [rtl/sup_cfg.svh]
// Purpose: Offsets, field positions, reset values and timing figures
// Assumes: 25 MHz system clock
// Notes: Included by bare name
`ifndef SUP_CFG_SVH
`define SUP_CFG_SVH
// ==========================================
// Clock and time base
`define CLK_MHZ 25
`define MS_US 1000
`define RST_LOW_US 1000
`define RST_HIGH_MS 320
`define STARTUP_CYCLES 3'd7
`define CAL_FREQ_HZ 200
`define WIN_STEP_MS 12'd16
`define WAKE_STEP_PER 12'd200
// ==========================================
// Device register offsets
`define ADDR_OSC_TRIM 4'h3
`define ADDR_WD_CTRL 4'h4
`define ADDR_IRQ_MASK 4'h5
`define ADDR_IRQ_FLAGS 4'h6
`define ADDR_SYS_STATUS 4'hf
// ==========================================
// Field positions
`define GATE_HI 7
`define GATE_LO 6
`define PULSE_GEN_STATUS_BIT 5
`define TIMER_EN_BIT 7
`define WIN_DIS_BIT 6
`define SWT_LSB 4
`define FLAG_WAKE_TIMER 1
`define FLAG_SERIAL_ERR 11
// ==========================================
// Reset and reinit values
`define RST_REG 12'h000
`define SYS_POR 6'h01
`define SYS_WAKE 6'h02
`define SYS_EXT 6'h04
`define SYS_WIN_FAIL 6'h08
`define GATE_CAL_ON 12'h040
`define GATE_CAL_OFF 12'h080
// ==========================================
// Controller own registers
`define HOST_STATUS 5'h10
`define HOST_CMD 5'h11
`define HOST_IFR_CLR 5'h12
`endif

// [rtl/sup_pkg.sv]
// Purpose: Types shared by both ends
// Assumes: Nothing
// Notes: Constants live in sup_cfg.svh
package sup_pkg;
  typedef enum logic [2:0] {ST_RST_LOW, ST_RST_HIGH, ST_SLEEP, ST_WINDOW, ST_WAKE} wd_state_e;
  typedef enum logic [1:0] {H_IDLE, H_STEP1, H_STEP2} host_state_e;
  typedef enum logic [2:0] {OP_NONE, OP_CAL_START, OP_CAL_STOP, OP_TIMER_RESTART, OP_WAKE_IRQ_EN} host_op_e;
  typedef logic [11:0] reg_word_t;
endpackage

// [rtl/sup_link_if.sv]
// Purpose: Serial register link and supervision pins between the ends
// Assumes: Both ends on one clock
// Notes: clr with rd reads then clears the flag register
`timescale 1ns/100ps
interface sup_link_if;
  logic wr;
  logic rd;
  logic clr;
  logic [3:0] addr;
  logic [11:0] wdata;
  logic [11:0] rdata;
  logic reset_out_n;
  logic irq_out_n;
  modport device_mp
  (
    input wr, rd, clr, addr, wdata,
    output rdata, reset_out_n, irq_out_n
  );
  modport host_mp
  (
    output wr, rd, clr, addr, wdata,
    input rdata, reset_out_n, irq_out_n
  );
endinterface

// [rtl/sup_device.sv]
// Purpose: Supervisor device end: watchdogs, wake timer, calibration, interrupts
// Assumes: Link strobes synchronous to clock_i, one cycle each
// Notes: Any watchdog control write restarts prescaler phase
`timescale 1ns/100ps
`include "sup_cfg.svh"
module sup_device
  import sup_pkg::*;
#(
  parameter int MS_CYC = `MS_US * `CLK_MHZ,
  parameter int HALF_CYC = (`CLK_MHZ * 1000000) / (2 * `CAL_FREQ_HZ),
  parameter int RST_HIGH_MS = `RST_HIGH_MS
)
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  sup_link_if.device_mp lnk,
  input wire logic can_wake_i,
  input wire logic wake_pin_i,
  input wire logic ext_reset_low_i,
  input wire logic [10:0] flag_event_i,
  input wire logic serial_error_i,
  output logic [4:0] trim_o,
  output logic sleep_o
);
  localparam int LOW_MS = (`RST_LOW_US + `MS_US - 1) / `MS_US;

  function automatic logic [11:0] win_close(input logic [3:0] wdt);
    win_close = 12'(({8'h00, wdt} + 12'h001) * `WIN_STEP_MS);
  endfunction

  wd_state_e st_r;
  wd_state_e st_nxt;
  logic restart;
  logic fail;
  logic [2:0] cyc_r;
  logic [$clog2(MS_CYC)-1:0] div_r;
  logic [11:0] ms_r;
  logic [$clog2(HALF_CYC)-1:0] pdiv_r;
  logic presc_r;
  logic [11:0] wper_r;
  logic [1:0] gate_r;
  logic [4:0] trim_r;
  logic pulse_gen_status_r;
  logic cal_rise_r;
  logic [7:0] wdc_r;
  logic [10:0] mask_r;
  logic [11:0] flags_r;
  logic [11:0] flags_nxt;
  logic [5:0] sys_r;
  logic [11:0] rdata_r;
  logic reset_n_r;
  logic irq_n_r;
  logic wake_prev_r;
  logic wdc_wr;
  logic trim_wr;
  logic ms_tick;
  logic rise;
  logic wake_exp;
  logic [11:0] wake_len;
  logic [11:0] close_ms;

  assign wdc_wr = lnk.wr && lnk.addr == `ADDR_WD_CTRL;
  assign trim_wr = lnk.wr && lnk.addr == `ADDR_OSC_TRIM;
  assign ms_tick = div_r == ($clog2(MS_CYC))'(MS_CYC - 1);
  assign rise = pdiv_r == ($clog2(HALF_CYC))'(HALF_CYC - 1) && !presc_r;
  assign wake_len = 12'(({10'h000, wdc_r[`SWT_LSB+:2]} + 12'h001) * `WAKE_STEP_PER);
  assign wake_exp = wdc_r[`TIMER_EN_BIT] && rise && wper_r == wake_len - 12'h001 && !wdc_wr;
  assign close_ms = win_close(wdc_r[3:0]);

  // ==========================================
  // Watchdog sequencing
  always_comb
  begin
    st_nxt = st_r;
    restart = 1'b0;
    fail = 1'b0;
    if (ext_reset_low_i)
    begin
      st_nxt = ST_RST_LOW;
      restart = 1'b1;
    end
    else
    begin
      unique case (st_r)
        ST_RST_LOW, ST_RST_HIGH:
        begin
          if (wdc_wr)
          begin
            st_nxt = lnk.wdata[`TIMER_EN_BIT] ? ST_WAKE : ST_WINDOW;
            restart = 1'b1;
          end
          else if (ms_tick && st_r == ST_RST_LOW && ms_r == 12'(LOW_MS - 1))
          begin
            st_nxt = ST_RST_HIGH;
            restart = 1'b1;
          end
          else if (ms_tick && st_r == ST_RST_HIGH && ms_r == 12'(RST_HIGH_MS - 1))
          begin
            st_nxt = (cyc_r == `STARTUP_CYCLES - 3'd1) ? ST_SLEEP : ST_RST_LOW;
            restart = 1'b1;
          end
        end
        ST_SLEEP:
        begin
          if (can_wake_i || (wake_pin_i != wake_prev_r))
          begin
            st_nxt = ST_RST_LOW;
            restart = 1'b1;
          end
        end
        ST_WINDOW:
        begin
          if (wdc_wr && !wdc_r[`WIN_DIS_BIT] && ms_r < {1'b0, close_ms[11:1]})
            fail = 1'b1;
          else if (wdc_wr)
          begin
            st_nxt = lnk.wdata[`TIMER_EN_BIT] ? ST_WAKE : ST_WINDOW;
            restart = 1'b1;
          end
          else if (!wdc_r[`WIN_DIS_BIT] && ms_tick && ms_r == close_ms - 12'h001)
            fail = 1'b1;
        end
        ST_WAKE:
        begin
          if (wdc_wr)
          begin
            st_nxt = lnk.wdata[`TIMER_EN_BIT] ? ST_WAKE : ST_WINDOW;
            restart = 1'b1;
          end
          else if (wake_exp)
          begin
            st_nxt = ST_WINDOW;
            restart = 1'b1;
          end
        end
      endcase
      if (fail)
      begin
        st_nxt = ST_RST_LOW;
        restart = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= ST_RST_LOW;
      cyc_r <= 3'd0;
      reset_n_r <= 1'b0;
      wake_prev_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      wake_prev_r <= wake_pin_i;
      reset_n_r <= !(st_nxt == ST_RST_LOW || st_nxt == ST_SLEEP);
      if (ext_reset_low_i)
        cyc_r <= 3'd0;
      else if (st_nxt == ST_RST_LOW && st_r == ST_RST_HIGH)
        cyc_r <= cyc_r + 3'd1;
      else if (st_nxt == ST_RST_LOW && st_r != ST_RST_LOW)
        cyc_r <= 3'd0;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_r <= '0;
      ms_r <= 12'h000;
    end
    else if (restart)
    begin
      div_r <= '0;
      ms_r <= 12'h000;
    end
    else if (ms_tick)
    begin
      div_r <= '0;
      ms_r <= ms_r + 12'h001;
    end
    else
      div_r <= div_r + 1'b1;
  end

  // ==========================================
  // Wake prescaler, shared with calibration wave
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pdiv_r <= '0;
      presc_r <= 1'b1;
      wper_r <= 12'h000;
    end
    else if (wdc_wr)
    begin
      pdiv_r <= '0;
      presc_r <= 1'b1;
      wper_r <= 12'h000;
    end
    else
    begin
      if (pdiv_r == ($clog2(HALF_CYC))'(HALF_CYC - 1))
      begin
        pdiv_r <= '0;
        presc_r <= !presc_r;
      end
      else
        pdiv_r <= pdiv_r + 1'b1;
      if (wake_exp)
        wper_r <= 12'h000;
      else if (rise && wdc_r[`TIMER_EN_BIT])
        wper_r <= wper_r + 12'h001;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      gate_r <= 2'b00;
      trim_r <= 5'h00;
      pulse_gen_status_r <= 1'b0;
      cal_rise_r <= 1'b0;
    end
    else
    begin
      if (trim_wr)
      begin
        gate_r <= lnk.wdata[`GATE_HI:`GATE_LO];
        // trim only with gate 00 or 11
        if (lnk.wdata[`GATE_HI] == lnk.wdata[`GATE_LO])
          trim_r <= lnk.wdata[4:0];
        if (lnk.wdata[`GATE_HI:`GATE_LO] == 2'b01 && gate_r != 2'b01)
          pulse_gen_status_r <= 1'b0;
        else if (lnk.wdata[`GATE_HI:`GATE_LO] == 2'b10 && gate_r == 2'b01)
          pulse_gen_status_r <= cal_rise_r || rise;
      end
      // A rise beside any register access except a watchdog control write still counts
      if (trim_wr && lnk.wdata[`GATE_HI:`GATE_LO] == 2'b01 && gate_r != 2'b01)
        cal_rise_r <= 1'b0;
      else if (wdc_wr)
        cal_rise_r <= 1'b0;
      else if (gate_r == 2'b01 && rise)
        cal_rise_r <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wdc_r <= 8'h00;
      mask_r <= 11'h000;
      flags_r <= `RST_REG;
      sys_r <= `SYS_POR;
    end
    else
    begin
      if (wdc_wr)
        wdc_r <= lnk.wdata[7:0];
      if (lnk.wr && lnk.addr == `ADDR_IRQ_MASK)
        mask_r <= lnk.wdata[10:0];
      flags_r <= flags_nxt;
      // startup cause then reinit on acknowledge
      if (ext_reset_low_i)
        sys_r <= `SYS_EXT;
      else if (fail)
        sys_r <= `SYS_WIN_FAIL;
      else if (st_r == ST_SLEEP && st_nxt == ST_RST_LOW)
        sys_r <= `SYS_WAKE;
      else if (wdc_wr && (st_r == ST_RST_LOW || st_r == ST_RST_HIGH))
        sys_r <= `SYS_POR;
    end
  end

  // flags kept until cleared, set wins
  always_comb
  begin
    flags_nxt = flags_r;
    if (lnk.wr && lnk.addr == `ADDR_IRQ_FLAGS)
      flags_nxt = flags_r & lnk.wdata;
    else if (lnk.rd && lnk.clr && lnk.addr == `ADDR_IRQ_FLAGS)
      flags_nxt = `RST_REG;
    flags_nxt = flags_nxt | {serial_error_i, flag_event_i};
    flags_nxt[`FLAG_WAKE_TIMER] = flags_nxt[`FLAG_WAKE_TIMER] | wake_exp;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_r <= `RST_REG;
      irq_n_r <= 1'b1;
    end
    else
    begin
      // gate low bit gates in the wave
      irq_n_r <= !(|(flags_r[10:0] & mask_r) || flags_r[`FLAG_SERIAL_ERR])
        && (gate_r[0] ? presc_r : 1'b1);
      if (lnk.rd)
      begin
        unique case (lnk.addr)
          `ADDR_OSC_TRIM: rdata_r <= {4'h0, gate_r, pulse_gen_status_r, trim_r};
          `ADDR_WD_CTRL: rdata_r <= {4'h0, wdc_r};
          `ADDR_IRQ_MASK: rdata_r <= {1'b0, mask_r};
          `ADDR_IRQ_FLAGS: rdata_r <= flags_r;
          `ADDR_SYS_STATUS: rdata_r <= {6'h00, sys_r};
          default: rdata_r <= `RST_REG;
        endcase
      end
    end
  end

  assign lnk.rdata = rdata_r;
  assign lnk.reset_out_n = reset_n_r;
  // gate 10 leaves only flags on the line
  assign lnk.irq_out_n = irq_n_r;
  assign trim_o = trim_r;
  assign sleep_o = st_r == ST_SLEEP;
endmodule

// [rtl/sup_host.sv]
// Purpose: Controller end: forwards software accesses, runs safe sequences
// Assumes: Software port strobes one cycle, never both at once
// Notes: Strobes during a running sequence are ignored, except status reads
`timescale 1ns/100ps
`include "sup_cfg.svh"
module sup_host
  import sup_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  sup_link_if.host_mp lnk,
  input wire logic [4:0] addr_i,
  input wire logic [11:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [11:0] rdata_o
);
  host_state_e hs_r;
  host_op_e op_r;
  logic [11:0] wdc_shadow_r;
  logic [11:0] mask_shadow_r;
  logic loc_sel_r;
  logic [11:0] loc_r;
  logic idle;
  logic fwd;

  assign idle = hs_r == H_IDLE;
  assign fwd = idle && !addr_i[4];

  // ==========================================
  // Sequencer
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hs_r <= H_IDLE;
      op_r <= OP_NONE;
    end
    else
    begin
      unique case (hs_r)
        H_IDLE:
        begin
          if (wr_i && addr_i == `HOST_CMD && wdata_i[2:0] != 3'd0)
          begin
            op_r <= host_op_e'(wdata_i[2:0]);
            hs_r <= H_STEP1;
          end
        end
        H_STEP1: hs_r <= H_STEP2;
        H_STEP2: hs_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wdc_shadow_r <= `RST_REG;
      mask_shadow_r <= `RST_REG;
    end
    else if (fwd && wr_i)
    begin
      if (addr_i[3:0] == `ADDR_WD_CTRL)
        wdc_shadow_r <= wdata_i;
      if (addr_i[3:0] == `ADDR_IRQ_MASK)
        mask_shadow_r <= wdata_i;
    end
    else if (hs_r == H_STEP1 && op_r == OP_WAKE_IRQ_EN)
      mask_shadow_r[`FLAG_WAKE_TIMER] <= 1'b1;
  end

  // ==========================================
  // Link drive
  always_comb
  begin
    lnk.wr = fwd && wr_i;
    lnk.rd = (fwd && rd_i) || (idle && rd_i && addr_i == `HOST_IFR_CLR);
    lnk.clr = idle && rd_i && addr_i == `HOST_IFR_CLR;
    lnk.addr = lnk.clr ? `ADDR_IRQ_FLAGS : addr_i[3:0];
    lnk.wdata = wdata_i;
    if (!idle)
    begin
      lnk.rd = 1'b0;
      lnk.clr = 1'b0;
      lnk.wr = 1'b1;
      unique case (op_r)
        OP_CAL_START:
        begin
          lnk.addr = (hs_r == H_STEP1) ? `ADDR_IRQ_FLAGS : `ADDR_OSC_TRIM;
          lnk.wdata = (hs_r == H_STEP1) ? `RST_REG : `GATE_CAL_ON;
        end
        OP_CAL_STOP:
        begin
          lnk.wr = hs_r == H_STEP1;
          lnk.addr = `ADDR_OSC_TRIM;
          lnk.wdata = `GATE_CAL_OFF;
        end
        OP_TIMER_RESTART:
        begin
          lnk.addr = `ADDR_WD_CTRL;
          lnk.wdata = wdc_shadow_r | 12'(1 << `TIMER_EN_BIT);
        end
        OP_WAKE_IRQ_EN:
        begin
          lnk.wr = hs_r == H_STEP1;
          lnk.addr = `ADDR_IRQ_MASK;
          lnk.wdata = mask_shadow_r | 12'(1 << `FLAG_WAKE_TIMER);
        end
        default:
          lnk.wr = 1'b0;
      endcase
    end
  end

  // ==========================================
  // Read path
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      loc_sel_r <= 1'b0;
      loc_r <= `RST_REG;
    end
    else if (rd_i)
    begin
      loc_sel_r <= !lnk.rd;
      if (addr_i == `HOST_STATUS)
        loc_r <= {9'h000, !idle, lnk.reset_out_n, lnk.irq_out_n};
      else
        loc_r <= `RST_REG;
    end
  end

  assign rdata_o = loc_sel_r ? loc_r : lnk.rdata;
endmodule

// [test/sup_link_chk.sv]
// Purpose: Concurrent checks on the supervisor link signals
// Assumes: One clock, reset_n_i asynchronous and active low
// Notes: Gate and mask fields are shadowed from link writes
`timescale 1ns/100ps
module sup_link_chk
#(
  parameter int MS_CYC = 10
)
(
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic wr,
  input wire logic rd,
  input wire logic clr,
  input wire logic [3:0] addr,
  input wire logic [11:0] wdata,
  input wire logic [11:0] rdata,
  input wire logic reset_out_n,
  input wire logic irq_out_n
);
  logic [1:0] gate_r;
  logic [10:0] mask_r;
  logic [15:0] low_cnt_r;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  // ==========
  // Shadow state
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      gate_r <= 2'h0;
      mask_r <= 11'h000;
    end
    else if (wr && addr == 4'h3)
      gate_r <= wdata[7:6];
    else if (wr && addr == 4'h5)
      mask_r <= wdata[10:0];
  end
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      low_cnt_r <= 16'h0000;
    else if (reset_out_n)
      low_cnt_r <= 16'h0000;
    else
      low_cnt_r <= low_cnt_r + 16'h0001;
  end
  // ==========
  // Properties
  property p_low_len;
    $rose(reset_out_n) |-> low_cnt_r >= MS_CYC - 1;
  endproperty
  a_low_len: assert property (p_low_len) else $error("reset low phase too short");
  property p_high_hold;
    $rose(reset_out_n) |-> reset_out_n[*8];
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("reset high phase cut short");
  property p_reinit;
    wr && addr == 4'h4 ##2 rd && addr == 4'hf |=> rdata[5:0] == 6'h01 || !reset_out_n;
  endproperty
  a_reinit: assert property (p_reinit) else $error("cause not reinitialised by ack");
  property p_clr_irq;
    rd && clr && addr == 4'h6 && !gate_r[0] |-> ##2 irq_out_n;
  endproperty
  a_clr_irq: assert property (p_clr_irq) else $error("interrupt held after clear");
  property p_cal_stop;
    wr && addr == 4'h3 && wdata[7:6] == 2'b10 |-> ##2 irq_out_n;
  endproperty
  a_cal_stop: assert property (p_cal_stop) else $error("wave not stopped");
  property p_phase;
    wr && addr == 4'h4 && gate_r == 2'b01 |-> ##2 irq_out_n[*8];
  endproperty
  a_phase: assert property (p_phase) else $error("wave phase not restarted");
  property p_mask_rd;
    rd && addr == 4'h5 |=> rdata[10:0] == mask_r;
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");
  property p_irq_cause;
    rd && addr == 4'h6 && !gate_r[0] |=> irq_out_n == !((|(rdata[10:0] & mask_r)) || rdata[11]);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt level disagrees with flags");
  c_cal: cover property (wr && addr == 4'h3 && wdata[7:6] == 2'b01);
  c_fail: cover property ($fell(reset_out_n));
  c_clr: cover property (rd && clr);
endmodule

// [test/tb_mcu_supervisor_watchdog_osc_cal.sv]
// Purpose: Self-checking bench for supervisor device and controller
// Assumes: Time base shortened through parameters
// Notes: Register table first, then hand-written cases
`timescale 1ns/100ps
module tb_mcu_supervisor_watchdog_osc_cal;
  localparam int MS = 10;
  localparam int HALF = 20;
  localparam int HIGH_MS = 5;
  localparam int CYCLE = MS + HIGH_MS * MS;
  typedef struct {logic [4:0] a; logic [11:0] d; logic [11:0] e;} row_s;
  logic clock_i = 1'b0;
  logic reset_n_i;
  logic can_wake_i;
  logic wake_pin_i;
  logic ext_reset_low_i;
  logic [10:0] flag_event_i;
  logic serial_error_i;
  logic [4:0] trim_o;
  logic sleep_o;
  logic [4:0] addr_i;
  logic [11:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [11:0] rdata_o;
  logic [11:0] rv;
  int n_fail = 0;
  int checks = 0;
  int i;
  int n;
  row_s rows [8] = '{'{5'h10, 12'h000, 12'h003}, '{5'h04, 12'h040, 12'h040}, '{5'h05, 12'h7ff, 12'h7ff},
    '{5'h05, 12'h002, 12'h002},
    '{5'h03, 12'h0c5, 12'h0c5}, '{5'h03, 12'h00a, 12'h00a}, '{5'h00, 12'h5a5, 12'h000}, '{5'h0f, 12'h03f, 12'h001}};
  sup_link_if sup_link_if_inst ();
  wire logic rst_w = sup_link_if_inst.reset_out_n;
  wire logic irq_w = sup_link_if_inst.irq_out_n;
  always #20 clock_i = ~clock_i;
  sup_device #(.MS_CYC(MS), .HALF_CYC(HALF), .RST_HIGH_MS(HIGH_MS)) sup_device_inst (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .lnk(sup_link_if_inst), .can_wake_i(can_wake_i), .wake_pin_i(wake_pin_i),
    .ext_reset_low_i(ext_reset_low_i), .flag_event_i(flag_event_i), .serial_error_i(serial_error_i),
    .trim_o(trim_o), .sleep_o(sleep_o));
  sup_host sup_host_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .lnk(sup_link_if_inst), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  sup_link_chk #(.MS_CYC(MS)) sup_link_chk_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .wr(sup_link_if_inst.wr), .rd(sup_link_if_inst.rd), .clr(sup_link_if_inst.clr), .addr(sup_link_if_inst.addr),
    .wdata(sup_link_if_inst.wdata), .rdata(sup_link_if_inst.rdata), .reset_out_n(rst_w), .irq_out_n(irq_w));
  // ==========
  // Tasks
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [11:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [11:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
    @(posedge clock_i);
  endtask
  task automatic wait_rst(input logic lvl);
    for (n = 0; n < 200 && rst_w !== lvl; n++)
      @(posedge clock_i);
  endtask
  task automatic pulse(input logic [11:0] f);
    flag_event_i <= f[10:0];
    serial_error_i <= f[11];
    @(posedge clock_i);
    flag_event_i <= 11'h000;
    serial_error_i <= 1'b0;
    cyc(3);
  endtask
  task automatic sleep_wake(input logic use_can, input int lo);
    for (n = 0; n < 600 && sleep_o !== 1'b1; n++)
      @(posedge clock_i);
    chk("sleep time", 12'h001, n >= lo && n <= 7 * CYCLE);
    if (use_can)
      can_wake_i <= 1'b1;
    else
      wake_pin_i <= ~wake_pin_i;
    @(posedge clock_i);
    can_wake_i <= 1'b0;
    cyc(3);
    chk("sleep left", 12'h000, sleep_o);
    wait_rst(1'b1);
    cyc(12);
    rd_reg(5'h0f, rv);
    chk("wake cause", 12'h002, rv);
    wr_reg(5'h04, 12'h040);
    rd_reg(5'h0f, rv);
    chk("cause after ack", 12'h001, rv);
  endtask
  // ==========
  // Main sequence
  initial
  begin
    reset_n_i = 1'b0;
    can_wake_i = 1'b0;
    wake_pin_i = 1'b0;
    ext_reset_low_i = 1'b0;
    flag_event_i = 11'h000;
    serial_error_i = 1'b0;
    addr_i = 5'h00;
    wdata_i = 12'h000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    cyc(20);
    reset_n_i <= 1'b1;
    wait_rst(1'b1);
    cyc(12);
    for (i = 0; i < 8; i++)
    begin
      wr_reg(rows[i].a, rows[i].d);
      rd_reg(rows[i].a, rv);
      chk("table", rows[i].e, rv);
    end
    chk("trim", 12'h00a, trim_o);
    pulse(12'h001);
    chk("masked flag", 12'h001, irq_w);
    pulse(12'h002);
    chk("enabled flag", 12'h000, irq_w);
    rd_reg(5'h12, rv);
    chk("flags", 12'h003, rv);
    cyc(2);
    chk("cleared", 12'h001, irq_w);
    pulse(12'h800);
    chk("serial error", 12'h000, irq_w);
    wr_reg(5'h06, 12'h000);
    cyc(2);
    chk("explicit clear", 12'h001, irq_w);
    wr_reg(5'h11, 12'h001);
    cyc(2);
    wr_reg(5'h04, 12'h040);
    cyc(2);
    for (n = 0; n < 100 && irq_w !== 1'b0; n++)
      @(posedge clock_i);
    for (n = 0; n < 100 && irq_w === 1'b0; n++)
      @(posedge clock_i);
    chk("wave low", HALF, n);
    for (n = 0; n < 100 && irq_w === 1'b1; n++)
      @(posedge clock_i);
    chk("wave high", HALF, n);
    wr_reg(5'h11, 12'h002);
    cyc(2);
    rd_reg(5'h03, rv);
    chk("pulse status", 12'h0aa, rv);
    chk("trim refused", 12'h00a, trim_o);
    chk("wave stopped", 12'h001, irq_w);
    wr_reg(5'h03, 12'h0d3);
    chk("trim gate 11", 12'h013, trim_o);
    wr_reg(5'h03, 12'h013);
    wr_reg(5'h05, 12'h000);
    wr_reg(5'h11, 12'h004);
    cyc(2);
    rd_reg(5'h05, rv);
    chk("wake enable", 12'h002, rv);
    wr_reg(5'h04, 12'h080);
    for (n = 0; n < 9000 && irq_w !== 1'b0; n++)
      @(posedge clock_i);
    chk("wake time", 12'h001, n > 7950 && n < 8050);
    chk("window suspended", 12'h001, rst_w);
    rd_reg(5'h12, rv);
    chk("wake flag", 12'h002, rv);
    wait_rst(1'b0);
    chk("window resumed", 12'h000, rst_w);
    rd_reg(5'h0f, rv);
    chk("fail cause", 12'h008, rv);
    wait_rst(1'b1);
    cyc(12);
    wr_reg(5'h04, 12'h000);
    cyc(100);
    wr_reg(5'h04, 12'h000);
    cyc(100);
    chk("in-window ack", 12'h001, rst_w);
    wr_reg(5'h04, 12'h000);
    cyc(20);
    wr_reg(5'h04, 12'h000);
    cyc(3);
    chk("early ack", 12'h000, rst_w);
    sleep_wake(1'b0, 7 * CYCLE - 15);
    ext_reset_low_i <= 1'b1;
    cyc(3);
    ext_reset_low_i <= 1'b0;
    wait_rst(1'b1);
    cyc(12);
    rd_reg(5'h0f, rv);
    chk("external cause", 12'h004, rv);
    sleep_wake(1'b1, 6 * CYCLE);
    wr_reg(5'h11, 12'h003);
    cyc(2);
    rd_reg(5'h04, rv);
    chk("timer restart", 12'h0c0, rv);
    chk("restart no reset", 12'h001, rst_w);
    reset_n_i <= 1'b0;
    cyc(2);
    chk("reset out", 12'h000, rst_w);
    chk("irq idle", 12'h001, irq_w);
    chk("trim reset", 12'h000, trim_o);
    chk("rdata reset", 12'h000, rdata_o);
    reset_n_i <= 1'b1;
    cyc(6);
    chk("startup low", 12'h000, rst_w);
    cyc(8);
    chk("startup high", 12'h001, rst_w);
    rd_reg(5'h0f, rv);
    chk("power-on cause", 12'h001, rv);
    finish_test;
  end
  initial
  begin
    cyc(40000);
    n_fail++;
    finish_test;
  end
endmodule
